// ===== logic/ext_bus_pkg.sv
`default_nettype none
package ext_bus_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ          = 100;
   localparam int QUARTER_FAST_NS  = 40;
   localparam int QUARTER_SLOW_NS  = 400;
   localparam int QUARTER_FAST_CYC =
      (QUARTER_FAST_NS * CLK_MHZ + 999) / 1000;
   localparam int QUARTER_SLOW_CYC =
      (QUARTER_SLOW_NS * CLK_MHZ + 999) / 1000;
   localparam int DIV_W            = 8;
   localparam int WAIT_CNT_W       = 4;
   localparam int QUARTER_SHIFT    = 2;

   // ------------------------------------------------------------------
   // Memory control register fields
   // ------------------------------------------------------------------
   localparam int WAIT_FIELD_MSB = 5;
   localparam int WAIT_FIELD_LSB = 4;
   localparam int WM_FIELD_MSB   = 1;
   localparam int WM_FIELD_LSB   = 0;

   localparam logic [1:0] WAIT_RESET     = 2'h3;
   localparam logic [1:0] WM_BYTE_WRITE  = 2'h0;
   localparam logic [1:0] WM_WORD_WRITE  = 2'h1;
   localparam logic [1:0] WM_BYTE_SELECT = 2'h2;

   // ------------------------------------------------------------------
   // Operations and states
   // ------------------------------------------------------------------
   localparam logic [1:0] OP_FETCH       = 2'h0;
   localparam logic [1:0] OP_TABLE_READ  = 2'h1;
   localparam logic [1:0] OP_TABLE_WRITE = 2'h2;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ADDR = 2'b01,
      S_HOLD = 2'b11,
      S_STRB = 2'b10
   } busState_t;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  op;
      logic [15:0] wordAddr;
      logic        byteLsb;
      logic [7:0]  tableLatch;
   } busReq_t;

   typedef struct packed {
      logic       eightBit;
      logic       waitEnable;
      logic [1:0] waitCount;
      logic [1:0] widthMode;
   } busCfg_t;

   typedef struct packed {
      logic [15:0] addrData;
      logic        addrDataOe;
      logic        addrLatch;
      logic        chipEnableN;
      logic        outputEnableN;
      logic        writeStrobeHighN;
      logic        writeStrobeLowN;
      logic        upperByteSelectN;
      logic        lowerByteSelectN;
      logic        byteAddressLsb;
   } busPins_t;

   localparam busPins_t PINS_IDLE = '{
      addrData:         16'h0000,
      addrDataOe:       1'b0,
      addrLatch:        1'b0,
      chipEnableN:      1'b1,
      outputEnableN:    1'b1,
      writeStrobeHighN: 1'b1,
      writeStrobeLowN:  1'b1,
      upperByteSelectN: 1'b1,
      lowerByteSelectN: 1'b1,
      byteAddressLsb:   1'b0
   };

   localparam busCfg_t CFG_RESET = '{
      eightBit:   1'b0,
      waitEnable: 1'b0,
      waitCount:  WAIT_RESET,
      widthMode:  WM_BYTE_SELECT
   };

endpackage
`default_nettype wire

// ===== logic/quarter_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module quarter_tick_gen (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic nrst,
   // Rate select
   input  wire logic slowClock,
   // Quarter-cycle enable
   output logic      tick
);

   logic [ext_bus_pkg::DIV_W-1:0] cnt_r;
   logic [ext_bus_pkg::DIV_W-1:0] cnt_nxt;
   logic [ext_bus_pkg::DIV_W-1:0] limit;
   logic                          tick_r;
   logic                          tick_nxt;

   // Bus phases simply follow the selected source; no rescaling
   always_comb begin
      limit = slowClock ?
         ext_bus_pkg::DIV_W'(ext_bus_pkg::QUARTER_SLOW_CYC - 1) :
         ext_bus_pkg::DIV_W'(ext_bus_pkg::QUARTER_FAST_CYC - 1); // RULE_12
      if (cnt_r >= limit) begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt  = cnt_r + 1'b1;
         tick_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!nrst)
      tick_r |=> !tick_r [*3]) // RULE_12
      else $error("quarter ticks closer than four cycles");

endmodule
`default_nettype wire

// ===== logic/wait_state_counter.sv
`timescale 1ns/1ps
`default_nettype none
module wait_state_counter (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // Control
   input  wire logic       load,
   input  wire logic [1:0] tcyCount,
   input  wire logic       tick,
   // Status
   output logic            busy
);

   logic [ext_bus_pkg::WAIT_CNT_W-1:0] cnt_r;
   logic [ext_bus_pkg::WAIT_CNT_W-1:0] cnt_nxt;

   // Wait states are whole instruction cycles, counted in quarters
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = ext_bus_pkg::WAIT_CNT_W'(tcyCount)
                   << ext_bus_pkg::QUARTER_SHIFT; // RULE_16
      end else if (tick && (cnt_r != '0)) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (cnt_r != '0);

endmodule
`default_nettype wire

// ===== logic/ext_mem_bus.sv
// Contract
// RULE_01: Byte-select table write puts the latch byte on both bus halves.
// RULE_02: Byte-select writes pulse only the high strobe, never the low.
// RULE_03: Byte address and byte selects follow table pointer bit 0.
// RULE_04: Flash uses byte address output; static RAM uses byte selects.
// RULE_05: Eight-bit width runs multiplexed with data on the low lines.
// RULE_06: Eight-bit fetch reads two bytes in one instruction cycle.
// RULE_07: Address latch strobe marks address valid before the data phase.
// RULE_08: Eight-bit fetch reads byte, toggles byte address, reads second.
// RULE_09: Eight-bit memory uses byte address output as its address LSB.
// RULE_10: Chip enable low on every access, held high during sleep.
// RULE_11: Eight-bit write: latch byte on both lanes, byte address from LSB.
// RULE_12: Slow run modes keep the bus running at the selected clock.
// RULE_13: System designer should adjust memory timing for slow clocks.
// RULE_14: Sleep or idle suspends the bus and freezes its outputs.
// RULE_15: In sleep or idle only chip enable and byte selects go high.
// RULE_16: Wait field adds zero to three cycles after table ops, default 3.
// RULE_17: Width field selects byte write, word write or byte select.
// RULE_18: Idle bus: lines tri-stated, strobes high, latch and LSB low.
// RULE_19: Access is address phase, data phase, then all strobes released.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_bus (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   // Core request
   input  wire logic                 reqValid,
   input  wire ext_bus_pkg::busReq_t req,
   output logic                      reqReady,
   // Core response
   output logic                      rspValid,
   output logic [15:0]               rspData,
   // Configuration and power state
   input  wire logic [7:0]           memoryControlReg,
   input  wire logic                 eightBitMode,
   input  wire logic                 waitEnable,
   input  wire logic                 slowClock,
   input  wire logic                 sleepMode,
   input  wire logic                 idleMode,
   // External bus pins
   input  wire logic [15:0]          addrDataIn,
   output logic [15:0]               addrDataOut,
   output logic                      addrDataOe,
   output logic                      addrLatch,
   output logic                      chipEnableN,
   output logic                      outputEnableN,
   output logic                      writeStrobeHighN,
   output logic                      writeStrobeLowN,
   output logic                      upperByteSelectN,
   output logic                      lowerByteSelectN,
   output logic                      byteAddressLsb
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   ext_bus_pkg::busState_t stateR;
   ext_bus_pkg::busState_t stateNxt;
   ext_bus_pkg::busPins_t  pinsR;
   ext_bus_pkg::busPins_t  pinsNxt;
   ext_bus_pkg::busReq_t   cmdR;
   ext_bus_pkg::busReq_t   cmdNxt;
   ext_bus_pkg::busCfg_t   cfgR;
   ext_bus_pkg::busCfg_t   cfgNxt;
   logic                   pendR;
   logic                   pendNxt;
   logic                   reqReadyR;
   logic                   reqReadyNxt;
   logic                   rspValidR;
   logic                   rspValidNxt;
   logic [15:0]            rspDataR;
   logic [15:0]            rspDataNxt;
   logic [7:0]             byte0R;
   logic [7:0]             byte0Nxt;
   logic [7:0]             holdLatchR;
   logic [7:0]             holdLatchNxt;
   logic [15:0]            syncA_r;
   logic [15:0]            syncB_r;
   logic                   quarterTick;
   logic                   waitBusy;
   logic                   waitLoad;
   logic                   suspend;
   logic                   eightFetch;
   logic                   lsb;

   function automatic logic [15:0] laneCopy(input logic [7:0] b);
      laneCopy = {b, b};
   endfunction

   assign suspend    = sleepMode | idleMode;
   assign eightFetch = cfgR.eightBit && (cmdR.op == ext_bus_pkg::OP_FETCH);
   assign lsb        = cmdR.byteLsb;

   // ------------------------------------------------------------------
   // Phase timing
   // ------------------------------------------------------------------
   // Slow sources stretch every phase; wait states do not rescale, so the
   // system must budget access time for the slowest clock it will use.
   quarter_tick_gen u_tick (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .slowClock (slowClock), // RULE_13
      .tick      (quarterTick)
   );

   wait_state_counter u_wait (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .load     (waitLoad),
      .tcyCount (cfgR.waitCount),
      .tick     (quarterTick && !suspend),
      .busy     (waitBusy)
   );

   // ------------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------------
   // Phases are four cycles or longer, so the two-cycle lag still lands
   // inside the strobe window.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA_r <= 16'h0000;
         syncB_r <= 16'h0000;
      end else begin
         syncA_r <= addrDataIn;
         syncB_r <= syncA_r;
      end
   end

   // ------------------------------------------------------------------
   // Bus sequencer
   // ------------------------------------------------------------------
   always_comb begin
      stateNxt     = stateR;
      pinsNxt      = pinsR;
      cmdNxt       = cmdR;
      cfgNxt       = cfgR;
      pendNxt      = pendR;
      byte0Nxt     = byte0R;
      holdLatchNxt = holdLatchR;
      rspValidNxt  = 1'b0;
      rspDataNxt   = rspDataR;
      waitLoad     = 1'b0;
      if (reqValid && reqReadyR) begin
         cmdNxt            = req;
         cfgNxt.eightBit   = eightBitMode; // RULE_05
         cfgNxt.waitEnable = waitEnable;
         cfgNxt.waitCount  = memoryControlReg[ext_bus_pkg::WAIT_FIELD_MSB:
                                              ext_bus_pkg::WAIT_FIELD_LSB];
         cfgNxt.widthMode  = memoryControlReg[ext_bus_pkg::WM_FIELD_MSB:
                                              ext_bus_pkg::WM_FIELD_LSB];
         pendNxt           = 1'b1;
      end
      if (suspend) begin
         // Everything else but chip enable and the byte selects keeps its level in sleep or idle
         pinsNxt.upperByteSelectN = 1'b1; // RULE_15
         pinsNxt.lowerByteSelectN = 1'b1; // RULE_15
      end else if (quarterTick) begin
         unique case (stateR)
            ext_bus_pkg::S_IDLE: begin
               if (pendR) begin
                  pendNxt                = 1'b0;
                  stateNxt               = ext_bus_pkg::S_ADDR;
                  pinsNxt                = ext_bus_pkg::PINS_IDLE;
                  pinsNxt.addrData       = cmdR.wordAddr;
                  pinsNxt.addrDataOe     = 1'b1;
                  pinsNxt.addrLatch      = 1'b1; // RULE_07
                  pinsNxt.byteAddressLsb =
                     (cmdR.op != ext_bus_pkg::OP_FETCH) && lsb; // RULE_04
               end
            end
            ext_bus_pkg::S_ADDR: begin
               stateNxt          = ext_bus_pkg::S_HOLD;
               pinsNxt.addrLatch = 1'b0; // RULE_19
               if (eightFetch) begin
                  pinsNxt.addrDataOe    = 1'b0;
                  pinsNxt.outputEnableN = 1'b0; // RULE_08
               end
            end
            ext_bus_pkg::S_HOLD: begin
               stateNxt = ext_bus_pkg::S_STRB;
               waitLoad = cfgR.waitEnable &&
                          (cmdR.op != ext_bus_pkg::OP_FETCH); // RULE_16
               if (eightFetch) begin
                  byte0Nxt               = syncB_r[7:0]; // RULE_06
                  pinsNxt.byteAddressLsb = 1'b1; // RULE_09
               end else if (cmdR.op == ext_bus_pkg::OP_TABLE_WRITE) begin
                  pinsNxt.addrData   = laneCopy(cmdR.tableLatch); // RULE_01
                  pinsNxt.addrDataOe = 1'b1;
                  if (cfgR.eightBit) begin
                     pinsNxt.writeStrobeLowN = 1'b0; // RULE_11
                  end else begin
                     case (cfgR.widthMode) // RULE_17
                        ext_bus_pkg::WM_BYTE_WRITE: begin
                           pinsNxt.writeStrobeHighN = !lsb;
                           pinsNxt.writeStrobeLowN  = lsb;
                        end
                        ext_bus_pkg::WM_WORD_WRITE: begin
                           if (!lsb) begin
                              // Even half waits in the holding latch
                              holdLatchNxt       = cmdR.tableLatch;
                              pinsNxt.addrDataOe = 1'b0;
                           end else begin
                              pinsNxt.addrData =
                                 {cmdR.tableLatch, holdLatchR};
                              pinsNxt.writeStrobeHighN = 1'b0;
                              pinsNxt.upperByteSelectN = 1'b0;
                              pinsNxt.lowerByteSelectN = 1'b0;
                           end
                        end
                        default: begin
                           pinsNxt.writeStrobeHighN = 1'b0; // RULE_02
                           pinsNxt.upperByteSelectN = !lsb; // RULE_03
                           pinsNxt.lowerByteSelectN = lsb;
                        end
                     endcase
                  end
               end else begin
                  pinsNxt.addrDataOe    = 1'b0;
                  pinsNxt.outputEnableN = 1'b0;
                  if (!cfgR.eightBit) begin
                     pinsNxt.upperByteSelectN = 1'b0;
                     pinsNxt.lowerByteSelectN = 1'b0;
                  end
               end
            end
            ext_bus_pkg::S_STRB: begin
               if (!waitBusy) begin
                  stateNxt    = ext_bus_pkg::S_IDLE;
                  pinsNxt     = ext_bus_pkg::PINS_IDLE; // RULE_18
                  rspValidNxt = 1'b1;
                  if (eightFetch) begin
                     rspDataNxt = {syncB_r[7:0], byte0R}; // RULE_08
                  end else if (cmdR.op == ext_bus_pkg::OP_TABLE_WRITE) begin
                     rspDataNxt = rspDataR;
                  end else if (cfgR.eightBit) begin
                     rspDataNxt = {8'h00, syncB_r[7:0]};
                  end else begin
                     rspDataNxt = syncB_r;
                  end
               end
            end
         endcase
      end
      pinsNxt.chipEnableN = suspend ||
                            (stateNxt == ext_bus_pkg::S_IDLE); // RULE_10
      reqReadyNxt = (stateNxt == ext_bus_pkg::S_IDLE) && !pendNxt &&
                    !suspend;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stateR     <= ext_bus_pkg::S_IDLE;
         pinsR      <= ext_bus_pkg::PINS_IDLE;
         cmdR       <= '0;
         cfgR       <= ext_bus_pkg::CFG_RESET;
         pendR      <= 1'b0;
         reqReadyR  <= 1'b0;
         rspValidR  <= 1'b0;
         rspDataR   <= 16'h0000;
         byte0R     <= 8'h00;
         holdLatchR <= 8'h00;
      end else begin
         stateR     <= stateNxt;
         pinsR      <= pinsNxt;
         cmdR       <= cmdNxt;
         cfgR       <= cfgNxt;
         pendR      <= pendNxt;
         reqReadyR  <= reqReadyNxt;
         rspValidR  <= rspValidNxt;
         rspDataR   <= rspDataNxt;
         byte0R     <= byte0Nxt;
         holdLatchR <= holdLatchNxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign reqReady         = reqReadyR;
   assign rspValid         = rspValidR;
   assign rspData          = rspDataR;
   assign addrDataOut      = pinsR.addrData;
   assign addrDataOe       = pinsR.addrDataOe;
   assign addrLatch        = pinsR.addrLatch;
   assign chipEnableN      = pinsR.chipEnableN;
   assign outputEnableN    = pinsR.outputEnableN;
   assign writeStrobeHighN = pinsR.writeStrobeHighN;
   assign writeStrobeLowN  = pinsR.writeStrobeLowN;
   assign upperByteSelectN = pinsR.upperByteSelectN;
   assign lowerByteSelectN = pinsR.lowerByteSelectN;
   assign byteAddressLsb   = pinsR.byteAddressLsb;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   logic selWrite;
   assign selWrite = (stateR == ext_bus_pkg::S_STRB) && !cfgR.eightBit &&
      (cmdR.op == ext_bus_pkg::OP_TABLE_WRITE) &&
      (cfgR.widthMode == ext_bus_pkg::WM_BYTE_SELECT);

   a_lanes_both_latch: assert property ( // RULE_01
      selWrite && !suspend |-> pinsR.addrData == laneCopy(cmdR.tableLatch))
      else $error("write data not on both lanes");
   a_low_strobe_idle: assert property ( // RULE_02
      selWrite |-> pinsR.writeStrobeLowN && !pinsR.writeStrobeHighN)
      else $error("wrong write strobe in byte select");
   a_byte_select_lsb: assert property ( // RULE_03
      selWrite && !suspend |-> pinsR.upperByteSelectN == !lsb &&
      pinsR.lowerByteSelectN == lsb && pinsR.byteAddressLsb == lsb)
      else $error("byte selects do not follow pointer bit 0");
   a_latch_before_data: assert property ( // RULE_07
      pinsR.addrLatch |-> pinsR.addrDataOe && pinsR.outputEnableN &&
      pinsR.writeStrobeHighN && pinsR.writeStrobeLowN)
      else $error("address latch overlaps data phase");
   a_fetch_byte_toggle: assert property ( // RULE_08
      $rose(pinsR.byteAddressLsb) && eightFetch |->
      !pinsR.outputEnableN && stateR == ext_bus_pkg::S_STRB)
      else $error("byte address toggled outside second read");
   a_fetch_word_pair: assert property ( // RULE_06
      rspValidR && eightFetch |-> rspDataR[7:0] == byte0R)
      else $error("fetch word lost its first byte");
   a_sleep_ce_high: assert property ( // RULE_10
      suspend |=> pinsR.chipEnableN && pinsR.upperByteSelectN &&
      pinsR.lowerByteSelectN)
      else $error("chip enable or byte select low in sleep");
   a_freeze_pins: assert property ( // RULE_14
      suspend && $past(suspend) |-> $stable(pinsR.addrData) &&
      $stable(pinsR.addrLatch) && $stable(pinsR.outputEnableN) &&
      $stable(pinsR.writeStrobeHighN) && $stable(stateR))
      else $error("bus moved while suspended");
   a_idle_levels: assert property ( // RULE_18
      stateR == ext_bus_pkg::S_IDLE |-> pinsR == ext_bus_pkg::PINS_IDLE)
      else $error("idle bus levels wrong");
   a_wait_stretch: assert property ( // RULE_16
      stateR == ext_bus_pkg::S_STRB && waitBusy |=>
      stateR == ext_bus_pkg::S_STRB)
      else $error("strobe released during wait states");

   c_eight_fetch: cover property (rspValidR && eightFetch);
   c_select_write: cover property (selWrite && lsb);
   c_suspend_mid: cover property (suspend &&
      stateR == ext_bus_pkg::S_STRB);
   c_wait_done: cover property ($fell(waitBusy));

endmodule
`default_nettype wire

// ===== test/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   // Pins from the controller
   input  wire logic        sys_clk,
   input  wire logic [15:0] addrDataOut,
   input  wire logic        addrLatch,
   input  wire logic        outputEnableN,
   input  wire logic        byteAddressLsb,
   // Read data back to the controller
   output logic [15:0]      addrDataIn
);
   logic [15:0] addrHeld = 16'h0000;
   logic [15:0] lastOut  = 16'h0000;
   // Word-wide flash: byte picked by the controller's byte address pin
   always_ff @(posedge sys_clk) begin
      if (addrLatch) begin
         addrHeld <= addrDataOut;
      end
      if (!outputEnableN) begin
         lastOut <= addrDataIn;
      end
   end
   // Released lines show the inverse so stale data never passes as fresh
   always_comb begin
      if (!outputEnableN) begin
         addrDataIn = {~addrHeld[7:0],
            byteAddressLsb ? ~addrHeld[7:0] : addrHeld[7:0]};
      end else begin
         addrDataIn = ~lastOut;
      end
   end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int Q = ext_bus_pkg::QUARTER_FAST_CYC;
   logic sys_clk = 1'b0, nrst = 1'b0, reqValid = 1'b0;
   ext_bus_pkg::busReq_t req = '0;
   logic [7:0] memoryControlReg = 8'h02;
   logic eightBitMode = 1'b0, waitEnable = 1'b0, slowClock = 1'b0;
   logic sleepMode = 1'b0, idleMode = 1'b0;
   logic reqReady, rspValid, addrDataOe, addrLatch, chipEnableN;
   logic outputEnableN, writeStrobeHighN, writeStrobeLowN;
   logic upperByteSelectN, lowerByteSelectN, byteAddressLsb;
   logic [15:0] rspData, addrDataIn, addrDataOut, latAddr, wData;
   logic sawWrL, wLsb, wUb, wLb, prevLsb;
   int fails = 0, cmp_count = 0, ceLen, toggles;

   ext_mem_bus dut (.sys_clk, .nrst, .reqValid, .req, .reqReady,
      .rspValid, .rspData, .memoryControlReg, .eightBitMode,
      .waitEnable, .slowClock, .sleepMode, .idleMode, .addrDataIn,
      .addrDataOut, .addrDataOe, .addrLatch, .chipEnableN,
      .outputEnableN, .writeStrobeHighN, .writeStrobeLowN,
      .upperByteSelectN, .lowerByteSelectN, .byteAddressLsb);
   ext_mem_model mem (.sys_clk, .addrDataOut, .addrLatch,
      .outputEnableN, .byteAddressLsb, .addrDataIn);

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic [15:0] pins();
      return {7'h00, addrDataOe, addrLatch, chipEnableN, outputEnableN,
         writeStrobeHighN, writeStrobeLowN, upperByteSelectN,
         lowerByteSelectN, byteAddressLsb};
   endfunction
   // Issues one request; stops at the response pulse, watching the pins
   task automatic access(input logic [1:0] op, input logic [15:0] a,
                         input logic lsb, input logic [7:0] lat);
      int n;
      for (n = 0; n < 500 && reqReady !== 1'b1; n++) @(negedge sys_clk);
      if (reqReady !== 1'b1) fails++;
      {ceLen, toggles, sawWrL, prevLsb} = '0;
      wData = ~{lat, lat};
      req = '{op: op, wordAddr: a, byteLsb: lsb, tableLatch: lat};
      reqValid = 1'b1;
      @(negedge sys_clk);
      reqValid = 1'b0;
      for (n = 0; n < 3000 && rspValid !== 1'b1; n++) begin
         @(negedge sys_clk);
         if (!chipEnableN) ceLen++;
         if (addrLatch) latAddr = addrDataOut;
         if (!writeStrobeLowN) sawWrL = 1'b1;
         if (!writeStrobeHighN || !writeStrobeLowN) begin
            {wData, wLsb, wUb, wLb} = {addrDataOut, byteAddressLsb,
               upperByteSelectN, lowerByteSelectN};
         end
         if (byteAddressLsb && !prevLsb && !outputEnableN) toggles++;
         prevLsb = byteAddressLsb;
      end
      if (rspValid !== 1'b1) begin
         fails++;
         print_verdict();
      end
      chk("pins after access", 16'h007E, pins());
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reads();
      int w;
      access(ext_bus_pkg::OP_FETCH, 16'h3C5A, 1'b0, 8'h00);
      chk("fetch16 data", 16'hA55A, rspData);
      chk("latched addr", 16'h3C5A, latAddr);
      chk("ce low cycles", 16'(3 * Q), 16'(ceLen));
      eightBitMode = 1'b1;
      access(ext_bus_pkg::OP_FETCH, 16'h1234, 1'b0, 8'h00);
      chk("fetch8 data", 16'hCB34, rspData);
      chk("fetch8 toggles", 16'h0001, 16'(toggles));
      chk("fetch8 length", 16'(3 * Q), 16'(ceLen));
      eightBitMode = 1'b0;
      waitEnable = 1'b1;
      for (w = 0; w < 4; w++) begin
         memoryControlReg = {2'h0, 2'(w), 2'h0, 2'h2};
         access(ext_bus_pkg::OP_TABLE_READ, 16'h00F0, 1'b0, 8'h00);
         chk("wait length", 16'((3 + 4 * w) * Q), 16'(ceLen));
      end
      waitEnable = 1'b0;
      slowClock = 1'b1;
      access(ext_bus_pkg::OP_FETCH, 16'h0077, 1'b0, 8'h00);
      chk("slow length", 16'(3 * ext_bus_pkg::QUARTER_SLOW_CYC),
         16'(ceLen));
      chk("slow data", 16'h8877, rspData);
      slowClock = 1'b0;
      $display("reads done");
   endtask
   task automatic t_writes();
      int m;
      for (m = 0; m < 4; m++) begin
         eightBitMode = m[1];
         access(ext_bus_pkg::OP_TABLE_WRITE, 16'h0100, m[0], 8'h5A + 8'(m));
         chk("write data", {2{8'h5A + 8'(m)}}, wData);
         chk("write lsb", 16'(m[0]), 16'(wLsb));
         if (!m[1]) begin
            chk("low strobe", 16'h0000, 16'(sawWrL));
            chk("byte sel", 16'({!m[0], m[0]}), 16'({wUb, wLb}));
         end
      end
      eightBitMode = 1'b0;
      memoryControlReg = 8'h30;
      access(ext_bus_pkg::OP_TABLE_WRITE, 16'h0100, 1'b0, 8'h11);
      chk("byte write low", 16'h0001, 16'(sawWrL));
      memoryControlReg = 8'h31;
      access(ext_bus_pkg::OP_TABLE_WRITE, 16'h0100, 1'b0, 8'h22);
      access(ext_bus_pkg::OP_TABLE_WRITE, 16'h0100, 1'b1, 8'h33);
      chk("word write", 16'h3322, wData);
      $display("writes done");
   endtask
   task automatic t_suspend(input logic useIdle);
      logic [15:0] snap;
      int n;
      access(ext_bus_pkg::OP_FETCH, 16'h0F0F, 1'b0, 8'h00);
      req.wordAddr = 16'h2D2D;
      reqValid = 1'b1;
      @(negedge sys_clk);
      reqValid = 1'b0;
      for (n = 0; n < 100 && chipEnableN; n++) @(negedge sys_clk);
      @(negedge sys_clk);
      snap = addrDataOut;
      {sleepMode, idleMode} = {!useIdle, useIdle};
      repeat (8) @(negedge sys_clk);
      chk("frozen bus", snap, addrDataOut);
      chk("frozen ctl", 16'h0001, {15'h0, addrLatch});
      chk("suspend high", 16'h0007, {13'h0, chipEnableN,
         upperByteSelectN, lowerByteSelectN});
      {sleepMode, idleMode} = 2'b00;
      for (n = 0; n < 100 && rspValid !== 1'b1; n++) @(negedge sys_clk);
      chk("resume done", 16'h0001, 16'(rspValid));
      $display("suspend done");
   endtask

   initial begin
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      chk("reset pins", 16'h007E, pins());
      t_reads();
      t_writes();
      t_suspend(1'b0);
      t_suspend(1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
